/* papt_regs.sv */
// Behaviour
// [RL1] driver four on only while bit set
// [RL2] driver four phase code selects quadrant
// [RL3] driver three on only while bit set
// [RL4] driver three phase code selects quadrant
// [RL5] shared edge class: fast, medium, slow
// [RL6] tuner one rail code, 100 mV steps
// [RL7] tuner one enable in top bit
// [RL8] tuner two rail code, 100 mV steps
// [RL9] tuner two enable in top bit
`timescale 1ns/1ps
`default_nettype none
`include "papt_params.svh"
module papt_regs
  import papt_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic wr_en_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  output logic [7:0] rdata_out,
  output logic hit_out,
  output logic amp3_on_out,
  output papt_phase_t amp3_phase_sel_out,
  output logic amp4_on_out,
  output papt_phase_t amp4_phase_sel_out,
  output papt_edge_t pair_b_edge_rate_out,
  output logic tuner1_on_out,
  output logic [6:0] tuner1_rail_code_out,
  output logic tuner2_on_out,
  output logic [6:0] tuner2_rail_code_out
);
  // register access comes from the already-synchronised serial front end
  logic [7:0] pair_b_r;
  logic [7:0] tuner1_r;
  logic [7:0] tuner2_r;
  wire sel_pair_b = (addr_in == `PAPT_OFS_AMP_PAIR_B);
  wire sel_tuner1 = (addr_in == `PAPT_OFS_TUNER_ONE);
  wire sel_tuner2 = (addr_in == `PAPT_OFS_TUNER_TWO);
  wire sel_any = sel_pair_b | sel_tuner1 | sel_tuner2;
  // unmapped addresses read as zero
  wire [7:0] rdata_nxt = sel_pair_b ? pair_b_r :
                         sel_tuner1 ? tuner1_r :
                         sel_tuner2 ? tuner2_r : 8'h00;
  wire [1:0] edge_code = pair_b_r[`PAPT_LSB_EDGE +: 2];
  // [RL5] edge class decode
  // codes 10 and 11 both mean slow
  wire papt_edge_t edge_nxt = (edge_code == 2'h0) ? PAPT_EDGE_FAST :
                              (edge_code == 2'h1) ? PAPT_EDGE_MEDIUM : PAPT_EDGE_SLOW;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pair_b_r <= `PAPT_RST_AMP_PAIR_B;
      tuner1_r <= `PAPT_RST_TUNER_ONE;
      tuner2_r <= `PAPT_RST_TUNER_TWO;
    end else if (wr_en_in) begin
      if (sel_pair_b) pair_b_r <= wdata_in;
      if (sel_tuner1) tuner1_r <= wdata_in;
      if (sel_tuner2) tuner2_r <= wdata_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rdata_out <= 8'h00;
      hit_out <= 1'b0;
    end else begin
      rdata_out <= rdata_nxt;
      hit_out <= sel_any;
    end
  end

  // outputs lag the register by one cycle so every port is a flop
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      amp3_on_out <= 1'b0;
      amp3_phase_sel_out <= PAPT_PH_0;
      amp4_on_out <= 1'b0;
      amp4_phase_sel_out <= PAPT_PH_0;
      pair_b_edge_rate_out <= PAPT_EDGE_FAST;
      tuner1_on_out <= 1'b0;
      tuner1_rail_code_out <= 7'h00;
      tuner2_on_out <= 1'b0;
      tuner2_rail_code_out <= 7'h00;
    end else begin
      // [RL1] driver four enable
      amp4_on_out <= pair_b_r[`PAPT_BIT_AMP4_ON];
      // [RL2] driver four phase
      amp4_phase_sel_out <= papt_phase_t'(pair_b_r[`PAPT_LSB_AMP4_PH +: 2]);
      // [RL3] driver three enable
      amp3_on_out <= pair_b_r[`PAPT_BIT_AMP3_ON];
      // [RL4] driver three phase
      amp3_phase_sel_out <= papt_phase_t'(pair_b_r[`PAPT_LSB_AMP3_PH +: 2]);
      pair_b_edge_rate_out <= edge_nxt;
      // [RL7] tuner one enable
      tuner1_on_out <= tuner1_r[`PAPT_BIT_TUNER_ON];
      // [RL6] tuner one rail
      tuner1_rail_code_out <= tuner1_r[6:0];
      // [RL9] tuner two enable
      tuner2_on_out <= tuner2_r[`PAPT_BIT_TUNER_ON];
      // [RL8] tuner two rail
      tuner2_rail_code_out <= tuner2_r[6:0];
    end
  end

  // [RL1] enable follows write
  chk_amp4_on_follow: assert property (@(posedge clk_in) disable iff (rst_in) // [RL1]
    wr_en_in && sel_pair_b |-> ##2 amp4_on_out == $past(wdata_in[0], 2))
    else $error("amp4 enable mismatch");
  // [RL2] phase follows write
  chk_amp4_phase_follow: assert property (@(posedge clk_in) disable iff (rst_in) // [RL2]
    wr_en_in && sel_pair_b |-> ##2 amp4_phase_sel_out == $past(wdata_in[2:1], 2))
    else $error("amp4 phase mismatch");
  // [RL3] enable follows write
  chk_amp3_on_follow: assert property (@(posedge clk_in) disable iff (rst_in) // [RL3]
    wr_en_in && sel_pair_b |-> ##2 amp3_on_out == $past(wdata_in[3], 2))
    else $error("amp3 enable mismatch");
  // [RL4] phase follows write
  chk_amp3_phase_follow: assert property (@(posedge clk_in) disable iff (rst_in) // [RL4]
    wr_en_in && sel_pair_b |-> ##2 amp3_phase_sel_out == $past(wdata_in[5:4], 2))
    else $error("amp3 phase mismatch");
  // [RL5] slow codes merge
  chk_edge_slow_code: assert property (@(posedge clk_in) disable iff (rst_in) // [RL5]
    wr_en_in && sel_pair_b && wdata_in[7] |-> ##2 pair_b_edge_rate_out == PAPT_EDGE_SLOW)
    else $error("edge class not slow");
  // [RL6] tuner one code
  chk_tuner1_rail: assert property (@(posedge clk_in) disable iff (rst_in) // [RL6]
    wr_en_in && sel_tuner1 |-> ##2 tuner1_rail_code_out == $past(wdata_in[6:0], 2))
    else $error("tuner1 rail mismatch");
  // [RL7] tuner one enable
  chk_tuner1_on: assert property (@(posedge clk_in) disable iff (rst_in) // [RL7]
    wr_en_in && sel_tuner1 |-> ##2 tuner1_on_out == $past(wdata_in[7], 2))
    else $error("tuner1 enable mismatch");
  // [RL8] tuner two code
  chk_tuner2_rail: assert property (@(posedge clk_in) disable iff (rst_in) // [RL8]
    wr_en_in && sel_tuner2 |-> ##2 tuner2_rail_code_out == $past(wdata_in[6:0], 2))
    else $error("tuner2 rail mismatch");
  // [RL9] tuner two enable
  chk_tuner2_on: assert property (@(posedge clk_in) disable iff (rst_in) // [RL9]
    wr_en_in && sel_tuner2 |-> ##2 tuner2_on_out == $past(wdata_in[7], 2))
    else $error("tuner2 enable mismatch");

  // fast and medium must not fold into slow
  // [RL5] fast code
  chk_edge_fast_code: assert property (@(posedge clk_in) disable iff (rst_in) // [RL5]
    wr_en_in && sel_pair_b && wdata_in[`PAPT_LSB_EDGE +: 2] == 2'h0
    |-> ##2 pair_b_edge_rate_out == PAPT_EDGE_FAST)
    else $error("edge class not fast");
  // [RL5] medium code
  chk_edge_medium_code: assert property (@(posedge clk_in) disable iff (rst_in) // [RL5]
    wr_en_in && sel_pair_b && wdata_in[`PAPT_LSB_EDGE +: 2] == 2'h1
    |-> ##2 pair_b_edge_rate_out == PAPT_EDGE_MEDIUM)
    else $error("edge class not medium");
  // readback lags the address by one cycle
  // [RL1] pair b readback
  chk_pair_b_readback: assert property (@(posedge clk_in) disable iff (rst_in) // [RL1]
    wr_en_in && sel_pair_b ##1 !wr_en_in && sel_pair_b
    |=> rdata_out == $past(wdata_in, 2) && hit_out)
    else $error("pair b readback mismatch");
  // [RL6] tuner one readback
  chk_tuner1_readback: assert property (@(posedge clk_in) disable iff (rst_in) // [RL6]
    wr_en_in && sel_tuner1 ##1 !wr_en_in && sel_tuner1
    |=> rdata_out == $past(wdata_in, 2) && hit_out)
    else $error("tuner1 readback mismatch");
  // [RL8] tuner two readback
  chk_tuner2_readback: assert property (@(posedge clk_in) disable iff (rst_in) // [RL8]
    wr_en_in && sel_tuner2 ##1 !wr_en_in && sel_tuner2
    |=> rdata_out == $past(wdata_in, 2) && hit_out)
    else $error("tuner2 readback mismatch");
  // reset is synchronous, so defaults show one edge later
  // [RL1] off after reset
  chk_rst_amp4_off: assert property (@(posedge clk_in) // [RL1]
    rst_in |=> !amp4_on_out)
    else $error("amp4 not off after reset");
  // [RL2] phase zero after reset
  chk_rst_amp4_phase: assert property (@(posedge clk_in) // [RL2]
    rst_in |=> amp4_phase_sel_out == PAPT_PH_0)
    else $error("amp4 phase not zero after reset");
  // [RL3] off after reset
  chk_rst_amp3_off: assert property (@(posedge clk_in) // [RL3]
    rst_in |=> !amp3_on_out)
    else $error("amp3 not off after reset");
  // [RL4] phase zero after reset
  chk_rst_amp3_phase: assert property (@(posedge clk_in) // [RL4]
    rst_in |=> amp3_phase_sel_out == PAPT_PH_0)
    else $error("amp3 phase not zero after reset");
  // [RL5] fast after reset
  chk_rst_edge_fast: assert property (@(posedge clk_in) // [RL5]
    rst_in |=> pair_b_edge_rate_out == PAPT_EDGE_FAST)
    else $error("edge class not fast after reset");
  // [RL6] code zero after reset
  chk_rst_tuner1_code: assert property (@(posedge clk_in) // [RL6]
    rst_in |=> tuner1_rail_code_out == 7'h00)
    else $error("tuner1 rail not zero after reset");
  // [RL7] off after reset
  chk_rst_tuner1_off: assert property (@(posedge clk_in) // [RL7]
    rst_in |=> !tuner1_on_out)
    else $error("tuner1 not off after reset");
  // [RL8] code zero after reset
  chk_rst_tuner2_code: assert property (@(posedge clk_in) // [RL8]
    rst_in |=> tuner2_rail_code_out == 7'h00)
    else $error("tuner2 rail not zero after reset");
  // [RL9] off after reset
  chk_rst_tuner2_off: assert property (@(posedge clk_in) // [RL9]
    rst_in |=> !tuner2_on_out)
    else $error("tuner2 not off after reset");
  // [RL3] enables hold without write
  chk_enables_hold: assert property (@(posedge clk_in) disable iff (rst_in) // [RL3]
    !wr_en_in |-> ##2 $stable({amp3_on_out, amp4_on_out, tuner1_on_out, tuner2_on_out}))
    else $error("enable changed without a write");
  cov_amp_both_on: cover property (@(posedge clk_in) disable iff (rst_in)
    amp3_on_out && amp4_on_out);
  cov_edge_medium: cover property (@(posedge clk_in) disable iff (rst_in)
    pair_b_edge_rate_out == PAPT_EDGE_MEDIUM);
  cov_tuner_full: cover property (@(posedge clk_in) disable iff (rst_in)
    tuner1_on_out && tuner1_rail_code_out == 7'h7F);
  cov_unmapped_read: cover property (@(posedge clk_in) disable iff (rst_in)
    !sel_any ##1 !hit_out);
  cov_slow_270: cover property (@(posedge clk_in) disable iff (rst_in)
    amp3_phase_sel_out == PAPT_PH_270 && pair_b_edge_rate_out == PAPT_EDGE_SLOW);
endmodule
`default_nettype wire

/* papt_params.svh */
`ifndef PAPT_PARAMS_SVH
`define PAPT_PARAMS_SVH
`define PAPT_OFS_AMP_PAIR_B 8'h21
`define PAPT_OFS_TUNER_ONE 8'h22
`define PAPT_OFS_TUNER_TWO 8'h23
`define PAPT_RST_AMP_PAIR_B 8'h00
`define PAPT_RST_TUNER_ONE 8'h00
`define PAPT_RST_TUNER_TWO 8'h00
`define PAPT_BIT_AMP4_ON 0
`define PAPT_LSB_AMP4_PH 1
`define PAPT_BIT_AMP3_ON 3
`define PAPT_LSB_AMP3_PH 4
`define PAPT_LSB_EDGE 6
`define PAPT_BIT_TUNER_ON 7
`define PAPT_EDGE_FAST_NS 10
`define PAPT_EDGE_MED_NS 20
`define PAPT_EDGE_SLOW_NS 40
`define PAPT_CLK_NS 40
`endif

/* papt_pkg.sv */
package papt_pkg;
  typedef enum logic [1:0] {
    PAPT_PH_0 = 2'h0,
    PAPT_PH_90 = 2'h1,
    PAPT_PH_180 = 2'h2,
    PAPT_PH_270 = 2'h3
  } papt_phase_t;
  typedef enum logic [1:0] {
    PAPT_EDGE_FAST = 2'h0,
    PAPT_EDGE_MEDIUM = 2'h1,
    PAPT_EDGE_SLOW = 2'h2
  } papt_edge_t;
endpackage

/* papt_host.sv */
`timescale 1ns/1ps
`default_nettype none
module papt_host (
  input wire logic clk_in,
  input wire logic [7:0] rdata_in,
  output logic wr_en_out,
  output logic [7:0] addr_out,
  output logic [7:0] wdata_out
);
  initial begin
    wr_en_out = 1'b0;
    addr_out = 8'h00;
    wdata_out = 8'hA5;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    wr_en_out <= 1'b1;
    addr_out <= a;
    wdata_out <= d;
    @(posedge clk_in);
    wr_en_out <= 1'b0;
    // released data must not still look valid
    wdata_out <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_in);
    addr_out <= a;
    repeat (2) @(posedge clk_in);
    #1 d = rdata_in;
  endtask
endmodule
`default_nettype wire

/* testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import papt_pkg::*;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  wire logic we, hit, a3, a4, t1, t2;
  wire logic [7:0] ad, wd, rd;
  wire logic [6:0] c1, c2;
  papt_phase_t p3, p4;
  papt_edge_t er;
  integer err_total = 0, samples_checked = 0, cycles = 0, i;
  logic [7:0] rv, pb;
  always #20 clk_in = ~clk_in;
  papt_host h (.clk_in(clk_in), .rdata_in(rd), .wr_en_out(we), .addr_out(ad), .wdata_out(wd));
  papt_regs dut (.clk_in(clk_in), .rst_in(rst_in), .wr_en_in(we), .addr_in(ad), .wdata_in(wd),
    .rdata_out(rd), .hit_out(hit), .amp3_on_out(a3), .amp3_phase_sel_out(p3),
    .amp4_on_out(a4), .amp4_phase_sel_out(p4), .pair_b_edge_rate_out(er),
    .tuner1_on_out(t1), .tuner1_rail_code_out(c1), .tuner2_on_out(t2),
    .tuner2_rail_code_out(c2));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e, input logic eh);
    h.rd(a, rv);
    chk("rdata", e, rv);
    chk("hit", {7'h00, eh}, {7'h00, hit});
  endtask
  task automatic outs(input logic [7:0] b, input logic [7:0] x, input logic [7:0] y);
    repeat (3) @(posedge clk_in);
    #1;
    chk("amp4_on", {7'h00, b[0]}, {7'h00, a4});
    chk("amp4_phase", {6'h00, b[2:1]}, {6'h00, p4});
    chk("amp3_on", {7'h00, b[3]}, {7'h00, a3});
    chk("amp3_phase", {6'h00, b[5:4]}, {6'h00, p3});
    chk("edge", {6'h00, (b[7] ? 2'h2 : b[7:6])}, {6'h00, er});
    chk("t1_code", {1'b0, x[6:0]}, {1'b0, c1});
    chk("t1_on", {7'h00, x[7]}, {7'h00, t1});
    chk("t2_code", {1'b0, y[6:0]}, {1'b0, c2});
    chk("t2_on", {7'h00, y[7]}, {7'h00, t2});
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      err_total++;
      finish_test();
    end
  end
  initial begin
    repeat (5) @(posedge clk_in);
    rst_in <= 1'b0;
    outs(8'h00, 8'h00, 8'h00);
    rdchk(8'h21, 8'h00, 1'b1);
    $display("test reset done");
    for (i = 0; i < 4; i++) begin
      pb = {i[1:0], i[1:0], i[0], 2'(3 - i), ~i[0]};
      h.wr(8'h21, pb);
      outs(pb, 8'h00, 8'h00);
      rdchk(8'h21, pb, 1'b1);
    end
    $display("test amp done");
    h.wr(8'h22, 8'hB2);
    h.wr(8'h23, 8'h7F);
    outs(pb, 8'hB2, 8'h7F);
    h.wr(8'h22, 8'h7F);
    h.wr(8'h23, 8'hB2);
    outs(pb, 8'h7F, 8'hB2);
    rdchk(8'h22, 8'h7F, 1'b1);
    rdchk(8'h23, 8'hB2, 1'b1);
    $display("test tuner done");
    h.wr(8'h24, 8'hFF);
    outs(pb, 8'h7F, 8'hB2);
    rdchk(8'h24, 8'h00, 1'b0);
    rdchk(8'h20, 8'h00, 1'b0);
    @(posedge clk_in);
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    outs(8'h00, 8'h00, 8'h00);
    rdchk(8'h22, 8'h00, 1'b1);
    rdchk(8'h21, 8'h00, 1'b1);
    $display("test unmapped and reset done");
    finish_test();
  end
endmodule
`default_nettype wire
